// [rtl/dss_cfg.svh]
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH
// Command word field positions
`define DSS_WORD_BITS     16
`define DSS_BIT_WDOG      15
`define DSS_BIT_PARITY    14
`define DSS_BIT_BANK      13
`define DSS_ADDR_HI       12
`define DSS_ADDR_LO       10
`define DSS_BIT_NORMAL    9
// Input register address codes
`define DSS_ADR_RDSEL     3'h0
`define DSS_ADR_DUTY      3'h1
`define DSS_ADR_CHCFG     3'h2
`define DSS_ADR_OCCFG     3'h4
`define DSS_ADR_RETRY     3'h5
`define DSS_ADR_GLOBAL    3'h6
`define DSS_ADR_CAL       3'h7
// Fixed calibration payload
`define DSS_CAL_PAYLOAD   9'h15b
// Readback select codes
`define DSS_RB_STATUS     3'h0
`define DSS_RB_FAULT      3'h1
`define DSS_RB_DUTY       3'h2
`define DSS_RB_CHCFG      3'h3
`define DSS_RB_OCCFG      3'h4
`define DSS_RB_RETRY      3'h5
`define DSS_RB_GLOBAL     3'h6
`define DSS_RB_DIAG       3'h7
// Reset values and ganging bit
`define DSS_RST_PAYLOAD   9'h000
`define DSS_GANG_BIT      6
`define DSS_SUPFAIL_EN    3
`endif

// [rtl/dss_pkg.sv]
package dss_pkg;
    // Per-channel configuration copy
    typedef struct packed {
        logic [8:0] duty;
        logic [8:0] chcfg;
        logic [8:0] occfg;
        logic [8:0] retry;
    } dss_chan_s;
    // Frame capture handed from link to system domain
    typedef struct packed {
        logic [15:0] word;
        logic        len_ok;
    } dss_frame_s;
    // Per-channel status inputs from the switch core
    typedef struct packed {
        logic [8:0] fault;
    } dss_stat_s;
endpackage

// [rtl/dss_spi_port.sv]
`timescale 1ns/1ps
`include "dss_cfg.svh"
module dss_spi_port #(
    parameter int WORD_BITS = `DSS_WORD_BITS
) (
    // System clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // Serial link pins
    input  wire logic                   sclk,
    input  wire logic                   chip_select_low,
    input  wire logic                   si,
    output logic                        so,
    output logic                        so_oe,
    // Device status inputs
    input  wire logic [8:0]             device_status,
    input  wire dss_pkg::dss_stat_s [1:0] chan_status,
    input  wire logic [8:0]             diag_status,
    input  wire logic                   supply_fail,
    input  wire logic                   normal_mode_flag,
    // Configuration outputs
    output dss_pkg::dss_chan_s [1:0]    chan_cfg,
    output logic [8:0]                  global_cfg,
    output logic [1:0]                  cal_strobe,
    output logic                        watchdog_toggle_bit
);
    initial begin
        if (WORD_BITS != 16) begin
            $error("dss_spi_port serves 16-bit words only");
        end
    end

    // Link domain state
    typedef struct packed {
        logic [15:0] shin;      // Input shift register
        logic [15:0] shout;     // Output shift register
        logic [3:0]  cnt;       // Bit counter within a word
        logic        whole;     // At least one whole word seen
    } dss_link_s;

    // System domain state
    typedef struct packed {
        dss_pkg::dss_chan_s [1:0] chan;
        logic [8:0]  glob;
        logic [1:0]  cal;
        logic        bank;       // Readback bank of previous command
        logic [2:0]  rbsel;      // Readback select of previous command
        logic        pfault;     // Parity fault of previous frame
        logic        wdog;       // Last watchdog bit
        logic [15:0] reply;      // Next word to return
        logic [2:0]  tsync;      // Toggle synchroniser and history
        logic [1:0]  rsync;      // Reset input synchroniser
        logic        last_sf;    // Previous supply fail level
        logic        gang_keep;  // Ganging bit held over supply fail
    } dss_sys_s;

    dss_link_s link;
    dss_link_s next_link;
    dss_sys_s  sys;
    dss_sys_s  next_sys;
    logic [1:0] rst_link;       // Reset synchroniser for link domain
    dss_pkg::dss_frame_s cap;   // Last word and its length verdict
    logic       so_q;           // Serial output bit after first edge
    logic [15:0] reply_hold;    // Reply captured at select fall

    // Odd parity check over a word
    function automatic logic par_odd(input logic [15:0] w);
        par_odd = ^w;
    endfunction

    // Reset release brought onto serial clock
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_link <= 2'h0;
        end else begin
            rst_link <= {rst_link[0], 1'h1};
        end
    end

    // Link logic: sample on rising edge, combinational next
    always_comb begin
        next_link = link;
        if (link.cnt == 4'h0 && !link.whole) begin
            // Frame start: rest of the previously selected reply
            next_link.shout = {reply_hold[14:0], 1'h0};
        end else if (link.cnt == 4'hf) begin
            // Word end: echo the word just taken, sixteen bits late
            next_link.shout = {link.shin[14:0], si};
        end else begin
            next_link.shout = {link.shout[14:0], 1'h0};
        end
        next_link.shin = {link.shin[14:0], si};
        next_link.cnt  = link.cnt + 4'h1;
        if (link.cnt == 4'hf) begin
            next_link.whole = 1'h1;
        end
    end

    // Link registers; frame start recovered by select reset
    always_ff @(posedge sclk or posedge chip_select_low) begin
        if (chip_select_low) begin
            link.shin  <= 16'h0000;
            link.shout <= 16'h0000;
            link.cnt   <= 4'h0;
            link.whole <= 1'h0;
        end else if (rst_link[1]) begin
            link.shin  <= next_link.shin;
            link.shout <= next_link.shout;
            link.cnt   <= next_link.cnt;
            link.whole <= next_link.whole;
        end
    end

    // Frame capture, kept across deselect for the system domain
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            cap.word   <= 16'h0000;
            cap.len_ok <= 1'h0;
        end else begin
            cap.word   <= {link.shin[14:0], si};
            cap.len_ok <= (link.cnt == 4'hf);
        end
    end

    // Frame start event: reply captured on falling select, link side
    always_ff @(negedge chip_select_low or negedge rst_n) begin
        if (!rst_n) begin
            reply_hold <= 16'h0000;
        end else begin
            reply_hold <= sys.reply;
        end
    end

    // Frame-end toggle flips at each deselect
    logic frame_tog;
    always_ff @(posedge chip_select_low or negedge rst_n) begin
        if (!rst_n) begin
            frame_tog <= 1'h0;
        end else begin
            frame_tog <= ~frame_tog;
        end
    end

    // System domain decode and register file
    always_comb begin
        logic        bank;
        logic [2:0]  adr;
        logic [8:0]  pay;
        logic        good;
        logic [8:0]  data;
        logic        rb_bank;
        logic [2:0]  rb_sel;
        logic [2:0]  soa;
        bank    = cap.word[`DSS_BIT_BANK];
        adr     = cap.word[`DSS_ADDR_HI:`DSS_ADDR_LO];
        pay     = cap.word[8:0];
        good    = 1'h0;
        data    = 9'h000;
        rb_bank = 1'h0;
        rb_sel  = 3'h0;
        soa     = 3'h0;
        next_sys = sys;
        next_sys.tsync = {sys.tsync[1:0], frame_tog};
        next_sys.rsync = {sys.rsync[0], 1'h1};
        next_sys.last_sf = supply_fail;
        next_sys.cal = 2'h0;
        // Catch ganging bit, masked by fail enable, while supply is good
        if (!supply_fail) begin
            next_sys.gang_keep = sys.glob[`DSS_SUPFAIL_EN] &
                                 sys.glob[`DSS_GANG_BIT];
        end
        if (sys.tsync[2] != sys.tsync[1]) begin
            // Length and parity verdict
            good = cap.len_ok && !par_odd(cap.word) &&
                   !cap.word[`DSS_BIT_NORMAL];
            next_sys.pfault = par_odd(cap.word);
            if (good) begin
                next_sys.wdog = cap.word[`DSS_BIT_WDOG];
                if (adr == `DSS_ADR_RDSEL) begin
                    next_sys.bank  = bank;
                    next_sys.rbsel = pay[2:0];
                end else if (adr == `DSS_ADR_DUTY) begin
                    next_sys.chan[bank].duty = pay;
                end else if (adr == `DSS_ADR_CHCFG) begin
                    next_sys.chan[bank].chcfg = pay;
                end else if (adr == `DSS_ADR_OCCFG) begin
                    next_sys.chan[bank].occfg = pay;
                end else if (adr == `DSS_ADR_RETRY) begin
                    next_sys.chan[bank].retry = pay;
                end else if (adr == `DSS_ADR_GLOBAL && !bank) begin
                    next_sys.glob = pay;
                end else if (adr == `DSS_ADR_CAL &&
                             pay == `DSS_CAL_PAYLOAD) begin
                    next_sys.cal[bank] = 1'h1;
                end
            end
        end
        // Supply failure clears payload, ganging kept when enabled
        if (supply_fail && !sys.last_sf) begin
            next_sys.chan = '0;
            next_sys.glob = `DSS_RST_PAYLOAD;
            next_sys.glob[`DSS_GANG_BIT] = sys.gang_keep;
        end
        // Build reply word from current selection
        rb_bank = next_sys.bank;
        rb_sel  = next_sys.rbsel;
        case (rb_sel)
            `DSS_RB_STATUS: data = device_status;
            `DSS_RB_FAULT:  data = chan_status[rb_bank].fault;
            `DSS_RB_DUTY:   data = next_sys.chan[rb_bank].duty;
            `DSS_RB_CHCFG:  data = next_sys.chan[rb_bank].chcfg;
            `DSS_RB_OCCFG:  data = next_sys.chan[rb_bank].occfg;
            `DSS_RB_RETRY:  data = next_sys.chan[rb_bank].retry;
            `DSS_RB_GLOBAL: data = next_sys.glob;
            default:        data = diag_status;
        endcase
        soa = rb_sel;
        next_sys.reply = {next_sys.wdog, next_sys.pfault,
                          (rb_sel == 3'h0 || rb_sel[2:1] == 2'h3)
                              ? 1'h0 : rb_bank,
                          soa, normal_mode_flag, data};
    end

    // System registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sys <= '0;
        end else begin
            sys <= next_sys;
        end
    end

    // Serial output: MSB of shift word, driven from the first falling edge until deselect
    always_ff @(negedge sclk or posedge chip_select_low) begin
        if (chip_select_low) begin
            so_q  <= 1'h0;
            so_oe <= 1'h0;
        end else begin
            so_q  <= link.shout[15];
            so_oe <= 1'h1;
        end
    end
    // Reply MSB stands from select fall until the first edge
    assign so = (link.cnt == 4'h0 && !link.whole) ? reply_hold[15] : so_q;

    // Configuration outputs from registers
    assign chan_cfg            = sys.chan;
    assign global_cfg          = sys.glob;
    assign cal_strobe          = sys.cal;
    assign watchdog_toggle_bit = sys.wdog;

    // Reply word's bank follows previous selection, except status, global and diag, which return bank zero
    reply_bank_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sys.rbsel == 3'h2 |-> sys.reply[13] == sys.bank)
        else $error("reply bank mismatch");
    // Word with bit 9 high never writes the global register
    bit9_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(sys.glob) && !$past(supply_fail) |->
        !$past(cap.word[9]))
        else $error("bit 9 word written");
    // Bad parity never writes the channel registers
    parity_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sys.tsync[2] != sys.tsync[1]) && par_odd(cap.word) |=>
        $stable(sys.chan))
        else $error("bad parity word written");
    // Parity flag tracks last frame
    parity_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sys.tsync[2] != sys.tsync[1]) |=>
        sys.pfault == $past(^cap.word))
        else $error("parity flag wrong");
    // Output enable low while deselected
    so_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        chip_select_low && $past(chip_select_low) |-> !so_oe)
        else $error("serial output driven while idle");
    // Global register never written from bank one
    glob_bank_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sys.tsync[2] != sys.tsync[1]) && cap.word[13] &&
        !supply_fail |=> $stable(sys.glob))
        else $error("global written from bank one");
    // Calibration strobe is one cycle
    cal_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        |sys.cal |=> ~|sys.cal)
        else $error("calibration strobe too long");
    // Reply carries the watchdog echo
    wdog_echo_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sys.reply[15] == sys.wdog)
        else $error("watchdog echo wrong");
endmodule

// [tb/dss_spi_master.sv]
`timescale 1ns/1ps
// Microcontroller side of the link: frames words onto the port
module dss_spi_master (
    // Serial link pins
    output logic      sclk,
    output logic      chip_select_low,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    // Idle: clock parked low, port deselected
    initial begin
        sclk = 1'b0;
        chip_select_low = 1'b1;
        si = 1'b0;
    end
    // One frame of nbits, sent from bit nbits-1 down; reply sampled rising
    task automatic xfer(input logic [47:0] tx, input int nbits,
                        output logic [47:0] rx);
        rx = '0;
        chip_select_low = 1'b0;  // Held low over all words
        for (int i = nbits - 1; i >= 0; i--) begin
            si = tx[i];  // Most significant bit first
            #16 rx[i] = so;  // Bit set up for this rising edge
            sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        #16 chip_select_low = 1'b1;
        si = ~si;  // Released line shows no stale level
    endtask
endmodule

// [tb/dss_spi_port_tb_top.sv]
`timescale 1ns/1ps
// Self-checking bench for the serial command port
module dss_spi_port_tb_top;
    logic                     clk_sys, rst_n, sclk, chip_select_low, si;
    logic                     so, so_oe, supply_fail, normal_mode_flag;
    logic                     watchdog_toggle_bit, wd;
    logic [8:0]               device_status, diag_status, global_cfg;
    logic [1:0]               cal_strobe;
    logic [47:0]              rx;
    dss_pkg::dss_stat_s [1:0] chan_status;
    dss_pkg::dss_chan_s [1:0] chan_cfg;
    int                       failures, checked, cal_cnt;
    // Device under test
    dss_spi_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
        .chip_select_low(chip_select_low), .si(si), .so(so), .so_oe(so_oe),
        .device_status(device_status), .chan_status(chan_status),
        .diag_status(diag_status), .supply_fail(supply_fail),
        .normal_mode_flag(normal_mode_flag), .chan_cfg(chan_cfg),
        .global_cfg(global_cfg), .cal_strobe(cal_strobe),
        .watchdog_toggle_bit(watchdog_toggle_bit));
    // Far-side master
    dss_spi_master u_master (.sclk(sclk), .chip_select_low(chip_select_low),
        .si(si), .so(so), .so_oe(so_oe));
    // System clock, 4 ns
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Counts calibration pulses of bank 1
    always @(posedge clk_sys) begin
        if (cal_strobe[1] === 1'b1) begin
            cal_cnt++;
        end
    end
    // Command word with even parity over all sixteen bits
    function automatic logic [15:0] mk(input logic b, input logic [2:0] a,
                                       input logic [8:0] p);
        logic [15:0] w;
        w = {wd, 1'b0, b, a, 1'b0, p};
        w[14] = ^w;
        return w;
    endfunction
    // Compares of words and of fields
    task automatic cmp16(input string n, input logic [15:0] e, s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp9(input string n, input logic [8:0] e, s);
        cmp16(n, {7'h00, e}, {7'h00, s});
    endtask
    // One frame, then the settle time the port needs
    task automatic frame(input logic [47:0] tx, input int n);
        @(posedge clk_sys);
        #1 u_master.xfer(tx, n, rx);
        repeat (8) @(posedge clk_sys);
        #1 wd = ~wd;  // Watchdog bit alternates every frame
    endtask
    task automatic send(input logic [15:0] w);
        frame({32'h0, w}, 16);
    endtask
    // Field of a channel bank by input address code
    function automatic logic [8:0] fld(input logic b, input logic [2:0] a);
        case (a)
            3'h1: return chan_cfg[b].duty;
            3'h2: return chan_cfg[b].chcfg;
            3'h4: return chan_cfg[b].occfg;
            default: return chan_cfg[b].retry;
        endcase
    endfunction
    // Every per-bank register and the global one
    task automatic t_write();
        logic [2:0] a;
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 4; k++) begin
                a = (k < 2) ? 3'(k + 1) : 3'(k + 2);
                send(mk(b[0], a, {b[0], a, 5'h15}));
            end
        end
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 4; k++) begin
                a = (k < 2) ? 3'(k + 1) : 3'(k + 2);
                cmp9("field", {b[0], a, 5'h15}, fld(b[0], a));
            end
        end
        send(mk(1'b0, 3'h6, 9'h055));
        cmp9("global", 9'h055, global_cfg);
        cmp16("so_oe", 16'h0, {15'h0, so_oe});
    endtask
    // Short, bit9 and bad parity frames leave registers alone
    task automatic t_bad();
        frame({32'h0, mk(1'b0, 3'h1, 9'h0f0)}, 15);
        send(mk(1'b0, 3'h1, 9'h0f0) ^ 16'h0240);
        send(mk(1'b0, 3'h1, 9'h0f0) ^ 16'h4000);
        cmp9("duty0", 9'h035, chan_cfg[0].duty);
        send(mk(1'b0, 3'h0, 9'h000));
        cmp16("pf_set", 16'h1, {15'h0, rx[14]});
        send(mk(1'b0, 3'h0, 9'h000));
        cmp16("pf_clr", 16'h0, {15'h0, rx[14]});
    endtask
    // Select bank 1 duty, then status; check whole reply words
    task automatic t_readback();
        logic w0;
        w0 = wd;
        send(mk(1'b1, 3'h0, 9'h002));
        cmp16("wdog", {15'h0, w0}, {15'h0, watchdog_toggle_bit});
        send(mk(1'b0, 3'h0, 9'h000));
        cmp16("rb_duty", {w0, 2'b01, 3'h2, 1'b1, 9'h135}, rx[15:0]);
        send(mk(1'b0, 3'h0, 9'h000));
        cmp16("rb_stat", {~w0, 5'h00, 1'b1, 9'h1a6}, rx[15:0]);
    endtask
    // Two words in one frame: echo delayed sixteen, last one kept
    task automatic t_chain();
        logic [15:0] w1, w2;
        w1 = mk(1'b0, 3'h1, 9'h033);
        w2 = mk(1'b0, 3'h1, 9'h0cc);
        frame({16'h0, w1, w2}, 32);
        cmp16("echo", w1, rx[15:0]);
        cmp9("last", 9'h0cc, chan_cfg[0].duty);
    endtask
    // Calibration only with the fixed payload
    task automatic t_cal();
        int c0;
        c0 = cal_cnt;
        send(mk(1'b1, 3'h7, 9'h15b));
        send(mk(1'b1, 3'h7, 9'h15a));
        cmp16("cal", 16'h1, 16'(cal_cnt - c0));
    endtask
    // Supply failure clears payload but keeps ganging when enabled
    task automatic t_supply();
        send(mk(1'b0, 3'h6, 9'h048));
        supply_fail = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 supply_fail = 1'b0;
        repeat (8) @(posedge clk_sys);
        cmp9("gang", 9'h040, global_cfg);
        cmp9("duty", 9'h000, chan_cfg[0].duty);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        cmp9("rst_glb", 9'h000, global_cfg);
    endtask
    // Verdict, in one place
    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #200000;
        failures++;
        finish_test();
    end
    // Main sequence; reset held high over every frame
    initial begin
        {failures, checked, cal_cnt} = '0;
        rst_n = 1'b0;
        wd = 1'b0;
        supply_fail = 1'b0;
        normal_mode_flag = 1'b1;
        device_status = 9'h1a6;
        diag_status = 9'h0c3;
        chan_status = {9'h111, 9'h022};
        repeat (5) @(posedge clk_sys);
        cmp9("rst_cfg", 9'h000, chan_cfg[1].retry);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        // Link reset needs two serial edges; this 16-bit frame is dropped
        frame(48'h0, 16);
        t_write();
        t_bad();
        t_readback();
        t_chain();
        t_cal();
        t_supply();
        finish_test();
    end
endmodule
